/* File: rtl/ispsq_top.sv */
// Serial in-system programming sequencer, core side with flash and EEPROM
`timescale 1ns/1ps
`default_nettype none
module ispsq_top
	import ispsq_pkg::*;
#(
	parameter int unsigned FLASH_WAIT_CYC = FLASH_PAGE_WAIT_CYC,
	parameter int unsigned EEP_WAIT_CYC   = EEPROM_BYTE_WAIT_CYC,
	parameter int unsigned ERASE_WAIT_CYC = CHIP_ERASE_WAIT_CYC
) (
	input  wire logic MCLK_I,
	input  wire logic RST_N_I,
	input  wire logic SCK_I,
	input  wire logic MOSI_I,
	input  wire logic PROG_RESET_I,
	output logic      MISO_O,
	output logic      PROG_ENABLED_O,
	output logic      PROGRAMMING_BUSY_FLAG_O
);
	logic [15:0]            flash_mem [2**WORD_ADDR_W];
	logic [7:0]             eep_mem   [2**EEP_ADDR_W];
	logic [15:0]            page_buf  [2**PAGE_OFS_W];

	logic [7:0]             rx_byte;
	logic                   rx_toggle;
	logic                   rx_toggle_s;
	logic                   rx_toggle_d;
	logic                   reset_pin_s;
	logic                   byte_evt;
	logic [7:0]             tx_word;
	logic [1:0]             byte_idx;
	logic [7:0]             b1;
	logic [7:0]             b2;
	logic [7:0]             b3;
	logic                   prog_en;
	ispsq_state_t           state;
	logic [TIMER_W-1:0]     timer;
	logic [WORD_ADDR_W-1:0] sweep;
	logic [PAGE_NUM_W-1:0]  busy_page;
	logic [EEP_ADDR_W-1:0]  busy_eep_addr;
	logic [7:0]             busy_eep_data;
	logic                   timer_is_flash;
	logic                   eep_pending;

	logic [WORD_ADDR_W-1:0] rd_flash_addr;
	logic [EEP_ADDR_W-1:0]  eep_addr;
	logic [15:0]            rd_flash_word;
	logic [7:0]             rd_flash_byte;
	logic [7:0]             rd_eep_byte;
	logic [PAGE_NUM_W-1:0]  wr_page;
	logic [PAGE_OFS_W-1:0]  ld_ofs;
	logic                   busy;
	logic                   instr_done;
	logic                   cmd_ok;
	logic [WORD_ADDR_W-1:0] commit_addr;

	ispsq_link u_link (
		.sck_i       (SCK_I),
		.link_rst_i  (PROG_RESET_I),
		.mosi_i      (MOSI_I),
		.tx_word_i   (tx_word),
		.rx_byte_o   (rx_byte),
		.rx_toggle_o (rx_toggle),
		.miso_o      (MISO_O)
	);

	ispsq_sync u_sync_toggle (
		.clk_i (MCLK_I),
		.d_i   (rx_toggle),
		.q_o   (rx_toggle_s)
	);

	ispsq_sync u_sync_reset (
		.clk_i (MCLK_I),
		.d_i   (PROG_RESET_I),
		.q_o   (reset_pin_s)
	);

	// Edge of the synchronised toggle marks one received byte
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			rx_toggle_d <= 1'b0;
		end else begin
			rx_toggle_d <= rx_toggle_s;
		end
	end

	assign byte_evt   = rx_toggle_s ^ rx_toggle_d;
	assign instr_done = byte_evt && (byte_idx == LAST_BYTE);
	assign busy       = (state != ISPSQ_IDLE);
	// Writes while busy are dropped; the programmer must not issue them
	assign cmd_ok     = prog_en && !busy;

	// Field extraction from the collected bytes
	assign rd_flash_addr = {1'b0, b2[4:0], rx_byte};
	assign eep_addr      = {b2[1:0], b3};
	assign wr_page       = {1'b0, b2[4:0], b3[7:6]};
	assign ld_ofs        = b3[PAGE_OFS_W-1:0];
	assign commit_addr   = {busy_page, sweep[PAGE_OFS_W-1:0]};

	// Flash read of the address in bytes two and three
	always_comb begin
		rd_flash_word = flash_mem[rd_flash_addr];
		rd_flash_byte = b1[H_SEL_BIT] ? rd_flash_word[15:8] : rd_flash_word[7:0];
		if ((state == ISPSQ_SWEEP_PAGE || state == ISPSQ_WAIT) &&
		    timer_is_flash && rd_flash_addr[WORD_ADDR_W-1:PAGE_OFS_W] == busy_page) begin
			rd_flash_byte = ERASED_BYTE;
		end
		if (state == ISPSQ_SWEEP_ERASE) begin
			rd_flash_byte = ERASED_BYTE;
		end
	end

	// EEPROM read, masked while that byte is being programmed
	always_comb begin
		rd_eep_byte = eep_mem[{b2[1:0], rx_byte}];
		if (eep_pending && busy_eep_addr == {b2[1:0], rx_byte}) begin
			rd_eep_byte = ERASED_BYTE;
		end
		if (state == ISPSQ_SWEEP_ERASE) begin
			rd_eep_byte = ERASED_BYTE;
		end
	end

	// Byte position within the four-byte instruction
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I || reset_pin_s) begin
			byte_idx <= 2'h0;
			b1       <= 8'h00;
			b2       <= 8'h00;
			b3       <= 8'h00;
		end else if (byte_evt) begin
			byte_idx <= byte_idx + 2'h1;
			unique case (byte_idx)
				2'h0: b1 <= rx_byte;
				2'h1: b2 <= rx_byte;
				2'h2: b3 <= rx_byte;
				2'h3: b3 <= b3;
			endcase
		end
	end

	// Reply for the next byte; default is an echo of the byte just taken
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I || reset_pin_s) begin
			tx_word <= IDLE_REPLY;
		end else if (byte_evt) begin
			unique case (byte_idx)
				2'h0: tx_word <= rx_byte;
				2'h1: tx_word <= rx_byte;
				2'h2: begin
					if (b1 == OP_POLL) begin
						tx_word <= {7'h00, busy};
					end else if (prog_en && (b1 & H_MASK) == OP_READ_FLASH) begin
						tx_word <= rd_flash_byte;
					end else if (prog_en && b1 == OP_READ_EEP) begin
						tx_word <= rd_eep_byte;
					end else begin
						tx_word <= rx_byte;
					end
				end
				2'h3: tx_word <= IDLE_REPLY;
			endcase
		end
	end

	// Programming mode holds only while the reset pin stays low
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I || reset_pin_s) begin
			prog_en <= 1'b0;
		end else if (instr_done && b1 == OP_ENABLE_B1 && b2 == OP_ENABLE_B2) begin
			prog_en <= 1'b1;
		end
	end

	// Page buffer loading; a commit sweep refills it with erased words
	always_ff @(posedge MCLK_I) begin
		if (instr_done && cmd_ok && (b1 & H_MASK) == OP_LOAD_PAGE) begin
			if (b1[H_SEL_BIT]) begin
				page_buf[ld_ofs][15:8] <= rx_byte;
			end else begin
				page_buf[ld_ofs][7:0] <= rx_byte;
			end
		end else if (state == ISPSQ_SWEEP_PAGE || state == ISPSQ_SWEEP_ERASE) begin
			// Erase clears the buffer too, so words never loaded commit as erased
			page_buf[sweep[PAGE_OFS_W-1:0]] <= {ERASED_BYTE, ERASED_BYTE};
		end
	end

	// Flash array: page commit or chip erase, one word per cycle
	always_ff @(posedge MCLK_I) begin
		if (state == ISPSQ_SWEEP_PAGE) begin
			flash_mem[commit_addr] <= page_buf[sweep[PAGE_OFS_W-1:0]];
		end else if (state == ISPSQ_SWEEP_ERASE) begin
			flash_mem[sweep] <= {ERASED_BYTE, ERASED_BYTE};
		end
	end

	// EEPROM array: erase sweep, or the held byte once its write time ends
	always_ff @(posedge MCLK_I) begin
		if (state == ISPSQ_SWEEP_ERASE && sweep < WORD_ADDR_W'(2**EEP_ADDR_W)) begin
			eep_mem[sweep[EEP_ADDR_W-1:0]] <= ERASED_BYTE;
		end else if (eep_pending && timer == '0) begin
			eep_mem[busy_eep_addr] <= busy_eep_data;
		end
	end

	// Self-timed programming sequencer
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			state          <= ISPSQ_IDLE;
			timer          <= '0;
			sweep          <= '0;
			busy_page      <= '0;
			busy_eep_addr  <= '0;
			busy_eep_data  <= 8'h00;
			timer_is_flash <= 1'b0;
			eep_pending    <= 1'b0;
		end else begin
			unique case (state)
				ISPSQ_IDLE: begin
					sweep <= '0;
					if (instr_done && cmd_ok) begin
						if (b1 == OP_WRITE_PAGE) begin
							state          <= ISPSQ_SWEEP_PAGE;
							busy_page      <= wr_page;
							timer          <= TIMER_W'(FLASH_WAIT_CYC - 1);
							timer_is_flash <= 1'b1;
						end else if (b1 == OP_ENABLE_B1 && b2[7:5] == OP_ERASE_B2) begin
							state          <= ISPSQ_SWEEP_ERASE;
							timer          <= TIMER_W'(ERASE_WAIT_CYC - 1);
							timer_is_flash <= 1'b0;
						end else if (b1 == OP_WRITE_EEP) begin
							state          <= ISPSQ_WAIT;
							busy_eep_addr  <= eep_addr;
							busy_eep_data  <= rx_byte;
							eep_pending    <= 1'b1;
							timer          <= TIMER_W'(EEP_WAIT_CYC - 1);
							timer_is_flash <= 1'b0;
						end
					end
				end
				ISPSQ_SWEEP_PAGE: begin
					timer <= timer - TIMER_W'(1);
					sweep <= sweep + WORD_ADDR_W'(1);
					if (sweep[PAGE_OFS_W-1:0] == {PAGE_OFS_W{1'b1}}) begin
						state <= ISPSQ_WAIT;
					end
				end
				ISPSQ_SWEEP_ERASE: begin
					timer <= timer - TIMER_W'(1);
					sweep <= sweep + WORD_ADDR_W'(1);
					if (sweep == {WORD_ADDR_W{1'b1}}) begin
						state <= ISPSQ_WAIT;
					end
				end
				ISPSQ_WAIT: begin
					if (timer == '0) begin
						state          <= ISPSQ_IDLE;
						eep_pending    <= 1'b0;
						timer_is_flash <= 1'b0;
					end else begin
						timer <= timer - TIMER_W'(1);
					end
				end
			endcase
		end
	end

	assign PROG_ENABLED_O          = prog_en;
	assign PROGRAMMING_BUSY_FLAG_O = busy;
endmodule
`default_nettype wire

/* File: rtl/ispsq_pkg.sv */
// Shared constants of the serial in-system programming sequencer
// What this block does
// - Link bits sampled on rising serial clock, returned bits change on falling edge.
// - When in sync, byte two 0x53 echoes while byte three shifts.
// - Page buffer loaded bytewise by six low word bits, low byte first.
// - Write-page commits buffer to the page named by seven address MSBs.
// - EEPROM byte write erases the location itself before writing.
// - Read instructions shift out stored flash or EEPROM content.
// - Reads inside a page being programmed return 0xFF until done.
// - All words of a page are programmed together.
// - Reading an EEPROM byte being programmed returns 0xFF until done.
// - Enable instruction AC 53 works only while reset pin is low.
// - AC followed by 100xxxxx erases flash and EEPROM.
// - Read flash 0010 H000 returns selected byte of addressed word.
// - Page load 0100 H000 stores byte four at six-bit word offset.
// - Write page takes page from byte two bits 4:0 and byte three 7:6.
// - Read EEPROM A0 returns byte at address byte two 1:0 and byte three.
// - Poll F0 returns busy flag in byte four bit zero.
package ispsq_pkg;
	localparam int unsigned CLK_PERIOD_NS          = 50;
	localparam real         FLASH_PAGE_WAIT_MS     = 4.5;
	localparam real         EEPROM_BYTE_WAIT_MS    = 3.6;
	localparam real         CHIP_ERASE_WAIT_MS     = 9.0;
	// Device must be done by the programmer's minimum wait, so round down
	localparam int unsigned FLASH_PAGE_WAIT_CYC    = int'($floor(FLASH_PAGE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int unsigned EEPROM_BYTE_WAIT_CYC   = int'($floor(EEPROM_BYTE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int unsigned CHIP_ERASE_WAIT_CYC    = int'($floor(CHIP_ERASE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));

	localparam int          TIMER_W      = 18;
	localparam int          WORD_ADDR_W  = 14;
	localparam int          PAGE_OFS_W   = 6;
	localparam int          PAGE_NUM_W   = 8;
	localparam int          EEP_ADDR_W   = 10;
	localparam int          H_SEL_BIT    = 3;

	localparam logic [7:0]  OP_ENABLE_B1  = 8'hac;
	localparam logic [7:0]  OP_ENABLE_B2  = 8'h53;
	localparam logic [2:0]  OP_ERASE_B2   = 3'h4;
	localparam logic [7:0]  OP_READ_FLASH = 8'h20;
	localparam logic [7:0]  OP_LOAD_PAGE  = 8'h40;
	localparam logic [7:0]  OP_WRITE_PAGE = 8'h4c;
	localparam logic [7:0]  OP_READ_EEP   = 8'ha0;
	localparam logic [7:0]  OP_WRITE_EEP  = 8'hc0;
	localparam logic [7:0]  OP_POLL       = 8'hf0;
	localparam logic [7:0]  H_MASK        = 8'hf7;
	localparam logic [7:0]  ERASED_BYTE   = 8'hff;
	localparam logic [7:0]  IDLE_REPLY    = 8'h00;
	localparam logic [1:0]  LAST_BYTE     = 2'h3;
	localparam logic [2:0]  LAST_BIT      = 3'h7;

	typedef enum logic [1:0] {
		ISPSQ_IDLE,
		ISPSQ_SWEEP_PAGE,
		ISPSQ_SWEEP_ERASE,
		ISPSQ_WAIT
	} ispsq_state_t;
endpackage

/* File: rtl/ispsq_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ispsq_sync (
	input  wire logic clk_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta;

	always_ff @(posedge clk_i) begin
		meta <= d_i;
		q_o  <= meta;
	end
endmodule
`default_nettype wire

/* File: rtl/ispsq_link.sv */
// Link-side byte shifter on the serial clock
`timescale 1ns/1ps
`default_nettype none
module ispsq_link
	import ispsq_pkg::*;
(
	input  wire logic       sck_i,
	input  wire logic       link_rst_i,
	input  wire logic       mosi_i,
	input  wire logic [7:0] tx_word_i,
	output logic [7:0]      rx_byte_o,
	output logic            rx_toggle_o,
	output logic            miso_o
);
	logic [2:0] bit_cnt;
	logic [2:0] fall_cnt;
	logic [6:0] rx_sh;

	// Link clock stops between frames, so the reset pin clears it directly
	always_ff @(posedge sck_i or posedge link_rst_i) begin
		if (link_rst_i) begin
			bit_cnt     <= 3'h0;
			rx_sh       <= 7'h00;
			rx_byte_o   <= 8'h00;
			rx_toggle_o <= 1'b0;
		end else begin
			bit_cnt <= bit_cnt + 3'h1;
			rx_sh   <= {rx_sh[5:0], mosi_i};
			if (bit_cnt == LAST_BIT) begin
				rx_byte_o   <= {rx_sh, mosi_i};
				rx_toggle_o <= ~rx_toggle_o;
			end
		end
	end

	// Falling edges pick the reply bit, so the output never moves while the clock is high
	always_ff @(negedge sck_i or posedge link_rst_i) begin
		if (link_rst_i) begin
			fall_cnt <= 3'h0;
		end else begin
			fall_cnt <= fall_cnt + 3'h1;
		end
	end

	// Reply word only moves in the gap between bytes, so no link flop samples it
	assign miso_o = tx_word_i[3'h7 - fall_cnt];
endmodule
`default_nettype wire

/* File: bench/ispsq_checker.sv */
// Pin-level checks on the programming sequencer
`timescale 1ns/1ps
`default_nettype none
module ispsq_checker #(
	parameter int unsigned FLASH_WAIT_CYC = 200,
	parameter int unsigned EEP_WAIT_CYC   = 100,
	parameter int unsigned ERASE_WAIT_CYC = 17000
) (
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire logic SCK_I,
	input wire logic MOSI_I,
	input wire logic PROG_RESET_I,
	input wire logic MISO_O,
	input wire logic PROG_ENABLED_O,
	input wire logic PROGRAMMING_BUSY_FLAG_O
);
	logic [31:0] busy_cnt;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I || !PROGRAMMING_BUSY_FLAG_O)
			busy_cnt <= 32'h0;
		else
			busy_cnt <= busy_cnt + 32'h1;
	end
	enable_hold_a: assert property (PROG_RESET_I [*4] |=> !PROG_ENABLED_O)
		else $error("mode kept while reset pin high");
	enable_cause_a: assert property ($rose(PROG_ENABLED_O) |-> !PROG_RESET_I && !SCK_I)
		else $error("mode entered outside a quiet low reset pin");
	enable_drop_a: assert property ($fell(PROG_ENABLED_O) |->
		$past(PROG_RESET_I, 2) || $past(PROG_RESET_I, 3) || $past(PROG_RESET_I, 4))
		else $error("mode lost without reset pin pulse");
	busy_mode_a: assert property ($rose(PROGRAMMING_BUSY_FLAG_O) |-> PROG_ENABLED_O)
		else $error("write started outside programming mode");
	busy_len_a: assert property ($fell(PROGRAMMING_BUSY_FLAG_O) |-> busy_cnt == FLASH_WAIT_CYC ||
		busy_cnt == EEP_WAIT_CYC || busy_cnt == ERASE_WAIT_CYC)
		else $error("busy length not a documented delay");
	busy_max_a: assert property (PROGRAMMING_BUSY_FLAG_O |-> busy_cnt <= ERASE_WAIT_CYC)
		else $error("busy longer than the erase delay");
	miso_edge_a: assert property ($changed(MISO_O) |-> !SCK_I)
		else $error("serial output moved while clock high");
	frame_done_a: assert property ($rose(PROGRAMMING_BUSY_FLAG_O) |-> !SCK_I [*2])
		else $error("operation started inside a frame");
	cover property ($rose(PROG_ENABLED_O));
	cover property ($rose(PROGRAMMING_BUSY_FLAG_O));
	cover property ($fell(PROGRAMMING_BUSY_FLAG_O));
endmodule
bind ispsq_top ispsq_checker #(
	.FLASH_WAIT_CYC(FLASH_WAIT_CYC),
	.EEP_WAIT_CYC  (EEP_WAIT_CYC),
	.ERASE_WAIT_CYC(ERASE_WAIT_CYC)
) u_chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .SCK_I(SCK_I), .MOSI_I(MOSI_I), .PROG_RESET_I(PROG_RESET_I),
	.MISO_O(MISO_O), .PROG_ENABLED_O(PROG_ENABLED_O), .PROGRAMMING_BUSY_FLAG_O(PROGRAMMING_BUSY_FLAG_O));
`default_nettype wire

/* File: bench/ispsq_prog_model.sv */
// Programmer model: serial master on the link pins
`timescale 1ns/1ps
`default_nettype none
module ispsq_prog_model (
	output logic      sck_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	// Odd gap keeps link edges off core edges; the core only counts cycles between bytes
	localparam int GAP_NS  = 607;
	localparam int HALF_NS = 80;
	initial begin
		sck_o = 1'b0;
		mosi_o = 1'b1;
	end
	task automatic xfer(input logic [31:0] ins, output logic [31:0] rep);
		for (int i = 31; i >= 0; i--) begin
			if (i % 8 == 7)
				#(GAP_NS);
			mosi_o = ins[i];
			#(HALF_NS);
			sck_o = 1'b1;
			rep[i] = miso_i;
			#(HALF_NS);
			sck_o = 1'b0;
			// Released line shows the inverse, never a held value
			if (i % 8 == 0)
				mosi_o = ~ins[i];
		end
	endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the serial programming sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ispsq_pkg::*;
	logic        mclk     = 1'b0;
	logic        rst_n    = 1'b0;
	logic        prog_rst = 1'b0;
	logic        sck;
	logic        mosi;
	logic        miso;
	logic        en;
	logic        busy;
	logic [31:0] rep;
	logic [7:0]  fl [logic [13:0]];
	int          fails       = 0;
	int          checks_done = 0;

	always #25 mclk = ~mclk;

	ispsq_top #(.FLASH_WAIT_CYC(400), .EEP_WAIT_CYC(300), .ERASE_WAIT_CYC(17000)) DUT (
		.MCLK_I                 (mclk),
		.RST_N_I                (rst_n),
		.SCK_I                  (sck),
		.MOSI_I                 (mosi),
		.PROG_RESET_I           (prog_rst),
		.MISO_O                 (miso),
		.PROG_ENABLED_O         (en),
		.PROGRAMMING_BUSY_FLAG_O(busy)
	);
	ispsq_prog_model prog (.sck_o(sck), .mosi_o(mosi), .miso_i(miso));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Instruction is acted on 3 core cycles after its last bit
	task automatic cmd(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] b4);
		prog.xfer({b1, b2, b3, b4}, rep);
		repeat (4) @(negedge mclk);
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			cmd(OP_POLL, 8'h00, 8'h00, 8'h00);
			n++;
		end while (rep[0] !== 1'b0 && n < 200);
		check("poll reply", rep[7:0], 8'h00);
		if (rep[0] !== 1'b0)
			summarize();
	endtask
	task automatic rd_flash(input logic [12:0] w, input logic h, input logic hide);
		cmd(OP_READ_FLASH | {4'h0, h, 3'h0}, {3'h0, w[12:8]}, w[7:0], 8'h00);
		check("flash byte", rep[7:0], (hide || !fl.exists({w, h})) ? ERASED_BYTE : fl[{w, h}]);
	endtask
	task automatic rd_eep(input logic [9:0] a, input logic [7:0] exp);
		cmd(OP_READ_EEP, {6'h0, a[9:8]}, a[7:0], 8'h00);
		check("eeprom byte", rep[7:0], exp);
	endtask

	initial begin
		logic [6:0] pg;
		logic [5:0] ofs;
		logic [9:0] ea;
		logic [7:0] d;
		void'($urandom(30));
		// Reset pin pulsed high while the link clock sits low
		@(posedge mclk);
		prog_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		check("enabled", {7'h0, en}, 8'h00);
		check("busy", {7'h0, busy}, 8'h00);
		repeat (2) @(posedge mclk);
		prog_rst <= 1'b0;
		repeat (20) @(negedge mclk);
		cmd(OP_ENABLE_B1, 8'h80, 8'h00, 8'h00);
		check("busy", {7'h0, busy}, 8'h00);
		check("enabled", {7'h0, en}, 8'h00);
		cmd(OP_ENABLE_B1, OP_ENABLE_B2, 8'($urandom), 8'($urandom));
		check("echo", rep[15:8], OP_ENABLE_B2);
		check("byte two reply", rep[23:16], OP_ENABLE_B1);
		check("enabled", {7'h0, en}, 8'h01);
		cmd(OP_ENABLE_B1, {OP_ERASE_B2, 5'($urandom)}, 8'h00, 8'h00);
		check("busy", {7'h0, busy}, 8'h01);
		rd_flash(13'($urandom), 1'b1, 1'b1);
		wait_ready();
		rd_flash(13'($urandom), 1'b0, 1'b0);
		rd_eep(10'($urandom), ERASED_BYTE);
		pg = 7'($urandom);
		for (int p = 0; p < 2; p++) begin
			pg = pg ^ 7'h40;
			for (int k = 0; k < 8; k++) begin
				ofs = (k == 0) ? 6'h00 : (k == 7) ? 6'h3f : 6'($urandom);
				for (int h = 0; h < 2; h++) begin
					d = 8'($urandom);
					fl[{pg, ofs, 1'(h)}] = d;
					cmd(OP_LOAD_PAGE | {4'h0, 1'(h), 3'h0}, 8'h00, {2'($urandom), ofs}, d);
				end
			end
			cmd(OP_WRITE_PAGE, {3'h0, pg[6:2]}, {pg[1:0], 6'($urandom)}, 8'h00);
			check("busy", {7'h0, busy}, 8'h01);
			rd_flash({pg, 6'($urandom)}, 1'b1, 1'b1);
			wait_ready();
			for (int k = 0; k < 6; k++) begin
				ofs = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : 6'($urandom);
				rd_flash({pg, ofs}, 1'b0, 1'b0);
				rd_flash({pg, ofs}, 1'b1, 1'b0);
			end
		end
		ea = 10'($urandom);
		for (int i = 0; i < 3; i++) begin
			d = (i == 2) ? 8'h00 : 8'($urandom) & 8'hfe;
			cmd(OP_WRITE_EEP, {6'h0, ea[9:8]}, ea[7:0], d);
			rd_eep(ea, ERASED_BYTE);
			wait_ready();
			rd_eep(ea, d);
		end
		@(posedge mclk);
		prog_rst <= 1'b1;
		repeat (5) @(posedge mclk);
		prog_rst <= 1'b0;
		repeat (5) @(negedge mclk);
		check("enabled", {7'h0, en}, 8'h00);
		cmd(OP_ENABLE_B1, OP_ENABLE_B2, 8'h00, 8'h00);
		check("echo", rep[15:8], OP_ENABLE_B2);
		summarize();
	end

	initial begin
		repeat (100000) @(posedge mclk);
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
